// ==== gnssu_pkg.sv ====
// constants, types and helpers shared by the receiver serial port and timing pulse logic
package gnssu_pkg;

  // ****************************************************
  // clock and line
  // ****************************************************
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned NUM_RATES = 7;
  localparam int unsigned RATE_BPS [0:6] = '{9600, 14400, 19200, 38400, 57600, 115200, 961200};
  localparam logic [2:0]  RATE_IDX_DEFAULT = 3'h5;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;
  localparam int unsigned DIV_W     = 16;
  localparam logic        LINE_IDLE = 1'b1;
  localparam logic        START_BIT = 1'b0;
  localparam logic [2:0]  LAST_BIT  = 3'h7;

  // ****************************************************
  // sentence set and commands
  // ****************************************************
  localparam int unsigned MSG_RMC = 0;
  localparam int unsigned MSG_GGA = 1;
  localparam int unsigned MSG_GSV = 2;
  localparam int unsigned MSG_GSA = 3;
  localparam logic [3:0]  MSG_MASK_DEFAULT = 4'hf;
  localparam logic [3:0]  CMD_SET_MSG  = 4'ha;
  localparam logic [3:0]  CMD_SET_RATE = 4'hb;

  // ****************************************************
  // timing pulse, real-time clock and transmit buffer depth
  // ****************************************************
  localparam int unsigned MIN_SATS      = 4;
  localparam int unsigned PPS_WIDTH_MS  = 100;
  localparam int unsigned PPS_WIDTH_CYC = CLK_HZ / 1000 * PPS_WIDTH_MS;
  localparam int unsigned SEC_CYC       = CLK_HZ;
  localparam int unsigned TICK_W        = 26;
  localparam int unsigned FIFO_DEPTH    = 16;

  // ****************************************************
  // types
  // ****************************************************
  typedef struct packed {
    logic [2:0] rate_idx;
    logic [3:0] msg_mask;
  } gnssu_cfg_t;

  typedef struct packed {
    logic [1:0] msg_type;
    logic [7:0] data;
  } gnssu_tx_word_t;

  typedef struct packed {
    logic [7:0] data;
    logic       frame_err;
  } gnssu_rx_t;

  typedef enum logic [1:0] {
    LN_IDLE,
    LN_START,
    LN_DATA,
    LN_STOP
  } gnssu_line_state_t;

  // cycles per bit, rounded to nearest
  function automatic logic [DIV_W-1:0] baud_div(input int unsigned clk_hz,
                                                input logic [2:0] idx);
    int unsigned r;
    int unsigned q;
    r = RATE_BPS[RATE_IDX_DEFAULT];
    if (32'(idx) < NUM_RATES) begin
      r = RATE_BPS[idx];
    end
    q = (clk_hz + r / 2) / r;
    return q[DIV_W-1:0];
  endfunction

endpackage

// ==== gnssu_fifo.sv ====
// transmit byte fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module gnssu_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // fill side
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  // drain side
  output logic      [WIDTH-1:0] o_rd_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    nxt_wr_ptr;
  logic [PW-1:0]    rd_ptr_ff;
  logic [PW-1:0]    nxt_rd_ptr;
  logic [PW:0]      count_ff;
  logic [PW:0]      nxt_count;
  logic             wr_ready_ff;
  logic             rd_valid_ff;
  logic             push;
  logic             pop;

  // ****************************************************
  // pointers and flags
  // ****************************************************
  always_comb begin
    push       = i_wr_valid && wr_ready_ff;
    pop        = i_rd_ready && rd_valid_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count  = count_ff;
    if (push) begin
      nxt_wr_ptr = (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd_ptr = (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      count_ff    <= '0;
      wr_ready_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
    end else begin
      wr_ptr_ff   <= nxt_wr_ptr;
      rd_ptr_ff   <= nxt_rd_ptr;
      count_ff    <= nxt_count;
      wr_ready_ff <= (nxt_count != FULL_CNT);
      rd_valid_ff <= (nxt_count != '0);
    end
  end

  // ****************************************************
  // storage
  // ****************************************************
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= i_wr_data;
    end
  end

  assign o_wr_ready = wr_ready_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_rd_data  = mem_ff[rd_ptr_ff];
endmodule
`default_nettype wire

// ==== gnssu_rx.sv ====
// serial receive path: pin synchroniser, framing and byte capture
`timescale 1ns/10ps
`default_nettype none
module gnssu_rx
  import gnssu_pkg::*;
(
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // line and control
  input  wire logic             i_rxd,
  input  wire logic             i_enable,
  input  wire logic [DIV_W-1:0] i_div,
  // received byte
  output gnssu_rx_t             o_rx,
  output logic                  o_valid
);
  logic              sync1_ff;
  logic              sync2_ff;
  logic              sync3_ff;
  logic              filt_ff;
  logic              nxt_filt;
  gnssu_line_state_t state_ff;
  gnssu_line_state_t nxt_state;
  logic [DIV_W-1:0]  cnt_ff;
  logic [DIV_W-1:0]  nxt_cnt;
  logic [2:0]        bit_ff;
  logic [2:0]        nxt_bit;
  logic [7:0]        shift_ff;
  logic [7:0]        nxt_shift;
  gnssu_rx_t         rx_ff;
  gnssu_rx_t         nxt_rx;
  logic              valid_ff;
  logic              nxt_valid;

  // ****************************************************
  // synchroniser
  // ****************************************************
  always_comb begin
    nxt_filt = (sync2_ff == sync3_ff) ? sync3_ff : filt_ff;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync1_ff <= LINE_IDLE;
      sync2_ff <= LINE_IDLE;
      sync3_ff <= LINE_IDLE;
      filt_ff  <= LINE_IDLE;
    end else begin
      sync1_ff <= i_rxd;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff  <= nxt_filt;
    end
  end

  // ****************************************************
  // framing
  // ****************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_bit   = bit_ff;
    nxt_shift = shift_ff;
    nxt_rx    = rx_ff;
    nxt_valid = 1'b0;
    case (state_ff)
      LN_IDLE: begin
        if (i_enable && filt_ff == START_BIT) begin
          nxt_state = LN_START;
          nxt_cnt   = i_div >> 1;
        end
      end
      LN_START: begin
        if (cnt_ff == '0) begin
          nxt_state = (filt_ff == START_BIT) ? LN_DATA : LN_IDLE;
          nxt_cnt   = i_div - 1'b1;
          nxt_bit   = '0;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      LN_DATA: begin
        if (cnt_ff == '0) begin
          nxt_shift = {filt_ff, shift_ff[7:1]};
          nxt_cnt   = i_div - 1'b1;
          nxt_bit   = bit_ff + 1'b1;
          if (bit_ff == LAST_BIT) begin
            nxt_state = LN_STOP;
          end
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      LN_STOP: begin
        if (cnt_ff == '0) begin
          nxt_rx.data      = shift_ff;
          nxt_rx.frame_err = (filt_ff != LINE_IDLE);
          nxt_valid        = 1'b1;
          nxt_state        = LN_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = LN_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_ff <= LN_IDLE;
      cnt_ff   <= '0;
      bit_ff   <= '0;
      shift_ff <= '0;
      rx_ff    <= '0;
      valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      bit_ff   <= nxt_bit;
      shift_ff <= nxt_shift;
      rx_ff    <= nxt_rx;
      valid_ff <= nxt_valid;
    end
  end

  assign o_rx    = rx_ff;
  assign o_valid = valid_ff;
endmodule
`default_nettype wire

// ==== gnssu_top.sv ====
// receiver host port: serial link, command decode, timing pulse and backed-up clock
//
// Summary of operation
// - link runs at 9600, 14400, 19200, 38400, 57600, 115200 or 961200 bps.
// - power-up rate 115200; frames carry eight data bits, no parity, one stop.
// - no handshake lines and no clocked mode; neither side paces the other.
// - transmit line carries sentences out; receive line takes host commands in.
// - default sentence set is RMC, GGA, GSV and GSA until a command changes it.
// - device is the DCE end; its transmit feeds host receive and vice versa.
// - with 3D fix from four or more satellites, one pulse per UTC second.
// - without a fix the timing output stays low with no pulses.
// - on backup supply, working state is held and the real-time clock keeps running; serial receive and transmit stop.
`timescale 1ns/10ps
`default_nettype none
module gnssu_top
  import gnssu_pkg::*;
#(
  parameter int unsigned CLK_FREQ_HZ = CLK_HZ,
  parameter int unsigned PPS_CYC     = PPS_WIDTH_CYC,
  parameter int unsigned SECOND_CYC  = SEC_CYC,
  parameter int unsigned TX_DEPTH    = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // sentence bytes from the positioning engine
  input  wire logic [7:0] i_tx_data,
  input  wire logic [1:0] i_tx_msg_type,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  // serial pins
  output logic            o_txd,
  input  wire logic       i_rxd,
  // received command bytes
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_rx_frame_err,
  // fix status and second marks
  input  wire logic       i_fix_3d,
  input  wire logic [4:0] i_sat_count,
  input  wire logic       i_utc_sec_mark,
  input  wire logic       i_backup_mode,
  // timing and state
  output logic            o_second_tick_output,
  output logic [3:0]      o_msg_mask,
  output logic [2:0]      o_rate_idx,
  output logic [31:0]     o_rtc_seconds
);
  localparam logic [TICK_W-1:0] PPS_LAST = TICK_W'(PPS_CYC - 1);
  localparam logic [TICK_W-1:0] SEC_LAST = TICK_W'(SECOND_CYC - 1);
  localparam logic [4:0]        SATS_MIN = 5'(MIN_SATS);
  localparam logic [2:0]        RATE_MAX = 3'(NUM_RATES - 1);

  gnssu_cfg_t        cfg_ff;
  gnssu_cfg_t        nxt_cfg;
  logic [DIV_W-1:0]  div_ff;
  logic [DIV_W-1:0]  nxt_div;
  gnssu_tx_word_t    fifo_in;
  gnssu_tx_word_t    fifo_out;
  logic              fifo_rd_valid;
  logic              fifo_rd_ready;
  gnssu_rx_t         rx_byte;
  logic              rx_valid;
  gnssu_line_state_t tx_state_ff;
  gnssu_line_state_t nxt_tx_state;
  logic [DIV_W-1:0]  tx_cnt_ff;
  logic [DIV_W-1:0]  nxt_tx_cnt;
  logic [2:0]        tx_bit_ff;
  logic [2:0]        nxt_tx_bit;
  logic [7:0]        tx_shift_ff;
  logic [7:0]        nxt_tx_shift;
  logic              txd_ff;
  logic              nxt_txd;
  logic              fix_ok;
  logic [TICK_W-1:0] pps_cnt_ff;
  logic [TICK_W-1:0] nxt_pps_cnt;
  logic              pps_ff;
  logic              nxt_pps;
  logic [TICK_W-1:0] sub_ff;
  logic [TICK_W-1:0] nxt_sub;
  logic [31:0]       sec_ff;
  logic [31:0]       nxt_sec;

  // ****************************************************
  // transmit buffer
  // ****************************************************
  assign fifo_in = '{msg_type: i_tx_msg_type, data: i_tx_data};

  gnssu_fifo #(
    .WIDTH ($bits(gnssu_tx_word_t)),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .i_sys_clk  (i_sys_clk),
    .i_rst      (i_rst),
    .i_wr_data  (fifo_in),
    .i_wr_valid (i_tx_valid),
    .o_wr_ready (o_tx_ready),
    .o_rd_data  (fifo_out),
    .o_rd_valid (fifo_rd_valid),
    .i_rd_ready (fifo_rd_ready)
  );

  // ****************************************************
  // receive path
  // ****************************************************
  gnssu_rx u_rx (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_rxd     (i_rxd),
    .i_enable  (!i_backup_mode),
    .i_div     (div_ff),
    .o_rx      (rx_byte),
    .o_valid   (rx_valid)
  );

  // ****************************************************
  // configuration by host command
  // ****************************************************
  always_comb begin
    nxt_cfg = cfg_ff;
    if (rx_valid && !rx_byte.frame_err) begin
      if (rx_byte.data[7:4] == CMD_SET_MSG) begin
        nxt_cfg.msg_mask = rx_byte.data[3:0];
      end else if (rx_byte.data[7:4] == CMD_SET_RATE && rx_byte.data[2:0] <= RATE_MAX
                   && rx_byte.data[3] == 1'b0) begin
        nxt_cfg.rate_idx = rx_byte.data[2:0];
      end
    end
    nxt_div = baud_div(CLK_FREQ_HZ, cfg_ff.rate_idx);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cfg_ff.rate_idx <= RATE_IDX_DEFAULT;
      cfg_ff.msg_mask <= MSG_MASK_DEFAULT;
      div_ff          <= baud_div(CLK_FREQ_HZ, RATE_IDX_DEFAULT);
    end else begin
      cfg_ff <= nxt_cfg;
      div_ff <= nxt_div;
    end
  end

  // ****************************************************
  // transmit framing, free running, no flow control
  // ****************************************************
  assign fifo_rd_ready = (tx_state_ff == LN_IDLE) && !i_backup_mode;

  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_tx_cnt   = tx_cnt_ff;
    nxt_tx_bit   = tx_bit_ff;
    nxt_tx_shift = tx_shift_ff;
    nxt_txd      = txd_ff;
    case (tx_state_ff)
      LN_IDLE: begin
        nxt_txd = LINE_IDLE;
        if (fifo_rd_ready && fifo_rd_valid && cfg_ff.msg_mask[fifo_out.msg_type]) begin
          nxt_tx_state = LN_START;
          nxt_tx_shift = fifo_out.data;
          nxt_tx_cnt   = div_ff - 1'b1;
          nxt_txd      = START_BIT;
        end
      end
      LN_START: begin
        if (tx_cnt_ff == '0) begin
          nxt_tx_state = LN_DATA;
          nxt_txd      = tx_shift_ff[0];
          nxt_tx_bit   = '0;
          nxt_tx_cnt   = div_ff - 1'b1;
        end else begin
          nxt_tx_cnt = tx_cnt_ff - 1'b1;
        end
      end
      LN_DATA: begin
        if (tx_cnt_ff == '0) begin
          nxt_tx_cnt = div_ff - 1'b1;
          if (tx_bit_ff == LAST_BIT) begin
            nxt_tx_state = LN_STOP;
            nxt_txd      = LINE_IDLE;
          end else begin
            nxt_tx_shift = tx_shift_ff >> 1;
            nxt_txd      = tx_shift_ff[1];
            nxt_tx_bit   = tx_bit_ff + 1'b1;
          end
        end else begin
          nxt_tx_cnt = tx_cnt_ff - 1'b1;
        end
      end
      LN_STOP: begin
        if (tx_cnt_ff == '0) begin
          nxt_tx_state = LN_IDLE;
        end else begin
          nxt_tx_cnt = tx_cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_tx_state = LN_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_state_ff <= LN_IDLE;
      tx_cnt_ff   <= '0;
      tx_bit_ff   <= '0;
      tx_shift_ff <= '0;
      txd_ff      <= LINE_IDLE;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_cnt_ff   <= nxt_tx_cnt;
      tx_bit_ff   <= nxt_tx_bit;
      tx_shift_ff <= nxt_tx_shift;
      txd_ff      <= nxt_txd;
    end
  end

  // ****************************************************
  // timing pulse
  // ****************************************************
  always_comb begin
    fix_ok      = i_fix_3d && (i_sat_count >= SATS_MIN);
    nxt_pps_cnt = pps_cnt_ff;
    nxt_pps     = pps_ff;
    if (!fix_ok) begin
      nxt_pps_cnt = '0;
      nxt_pps     = 1'b0;
    end else if (i_utc_sec_mark) begin
      nxt_pps_cnt = PPS_LAST;
      nxt_pps     = 1'b1;
    end else if (pps_cnt_ff != '0) begin
      nxt_pps_cnt = pps_cnt_ff - 1'b1;
    end else begin
      nxt_pps = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pps_cnt_ff <= '0;
      pps_ff     <= 1'b0;
    end else begin
      pps_cnt_ff <= nxt_pps_cnt;
      pps_ff     <= nxt_pps;
    end
  end

  // ****************************************************
  // real-time clock, runs in backup mode too
  // ****************************************************
  always_comb begin
    nxt_sub = sub_ff + 1'b1;
    nxt_sec = sec_ff;
    if ((fix_ok && i_utc_sec_mark) || sub_ff >= SEC_LAST) begin
      nxt_sub = '0;
      nxt_sec = sec_ff + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sub_ff <= '0;
      sec_ff <= '0;
    end else begin
      sub_ff <= nxt_sub;
      sec_ff <= nxt_sec;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign o_txd                = txd_ff;
  assign o_rx_data            = rx_byte.data;
  assign o_rx_valid           = rx_valid;
  assign o_rx_frame_err       = rx_byte.frame_err;
  assign o_second_tick_output = pps_ff;
  assign o_msg_mask           = cfg_ff.msg_mask;
  assign o_rate_idx           = cfg_ff.rate_idx;
  assign o_rtc_seconds        = sec_ff;
endmodule
`default_nettype wire

// ==== gnssu_fifo_unused.sv ====
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== gnssu_top_asserts.sv ====
// checker for the receiver host port
`timescale 1ns/10ps
`default_nettype none
module gnssu_top_asserts #(
  parameter int unsigned PPS_CYC    = 8,
  parameter int unsigned SECOND_CYC = 50
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // watched ports
  input  wire logic        o_txd,
  input  wire logic [7:0]  o_rx_data,
  input  wire logic        o_rx_valid,
  input  wire logic        o_rx_frame_err,
  input  wire logic        i_fix_3d,
  input  wire logic [4:0]  i_sat_count,
  input  wire logic        i_utc_sec_mark,
  input  wire logic        o_second_tick_output,
  input  wire logic [3:0]  o_msg_mask,
  input  wire logic [2:0]  o_rate_idx,
  input  wire logic [31:0] o_rtc_seconds
);
  // ****************************************************
  // pulse age tracker and properties
  // ****************************************************
  localparam int RTC_LIM = SECOND_CYC;
  logic        fix_ok;
  logic [31:0] since_ff, nxt_since;
  assign fix_ok = i_fix_3d && (i_sat_count >= 5'h04);
  always_comb begin
    nxt_since = 32'h0;
    if (i_utc_sec_mark && fix_ok) begin
      nxt_since = 32'h1;
    end else if (fix_ok && (since_ff != 32'h0) && (since_ff <= PPS_CYC)) begin
      nxt_since = since_ff + 32'h1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      since_ff <= 32'h0;
    end else begin
      since_ff <= nxt_since;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence mask_cmd_s;
    o_rx_valid && !o_rx_frame_err && (o_rx_data[7:4] == 4'ha);
  endsequence
  sequence rate_cmd_s;
    o_rx_valid && !o_rx_frame_err && (o_rx_data[7:4] == 4'hb) && (o_rx_data[3:0] <= 4'h6);
  endsequence
  idle_after_reset_a: assert property ($past(i_rst) |-> o_txd)
    else $error("serial out not idle after reset");
  tick_shape_a: assert property (
    o_second_tick_output == ((since_ff != 32'h0) && (since_ff <= PPS_CYC)))
    else $error("timing pulse shape wrong");
  tick_rise_a: assert property (i_utc_sec_mark && fix_ok |=> o_second_tick_output)
    else $error("timing pulse missing after mark");
  nofix_low_a: assert property (!fix_ok |=> !o_second_tick_output)
    else $error("timing pulse without fix");
  rx_pulse_a: assert property (o_rx_valid |=> !o_rx_valid)
    else $error("receive valid longer than one cycle");
  rx_hold_a: assert property (!o_rx_valid |-> $stable(o_rx_data) && $stable(o_rx_frame_err))
    else $error("receive data changed without valid");
  mask_cmd_a: assert property (mask_cmd_s |=> o_msg_mask == $past(o_rx_data[3:0]))
    else $error("sentence set not taken");
  rate_cmd_a: assert property (rate_cmd_s |=> o_rate_idx == $past(o_rx_data[2:0]))
    else $error("rate not taken");
  cfg_hold_a: assert property (!o_rx_valid |=> $stable(o_msg_mask) && $stable(o_rate_idx))
    else $error("settings changed without command");
  rtc_step_a: assert property ((o_rtc_seconds - $past(o_rtc_seconds)) <= 32'h1)
    else $error("seconds count jumped");
  rtc_run_a: assert property (
    $changed(o_rtc_seconds) |-> ##[1:RTC_LIM] $changed(o_rtc_seconds))
    else $error("seconds count stalled");
endmodule
bind gnssu_top gnssu_top_asserts #(
  .PPS_CYC    (PPS_CYC),
  .SECOND_CYC (SECOND_CYC)
) gnssu_top_asserts_i (
  .i_sys_clk (i_sys_clk), .i_rst (i_rst), .o_txd (o_txd), .o_rx_data (o_rx_data),
  .o_rx_valid (o_rx_valid), .o_rx_frame_err (o_rx_frame_err), .i_fix_3d (i_fix_3d),
  .i_sat_count (i_sat_count), .i_utc_sec_mark (i_utc_sec_mark),
  .o_second_tick_output (o_second_tick_output), .o_msg_mask (o_msg_mask),
  .o_rate_idx (o_rate_idx), .o_rtc_seconds (o_rtc_seconds)
);
`default_nettype wire

// ==== gnssu_host.sv ====
// behavioural host terminal on the far side of the serial link
`timescale 1ns/10ps
`default_nettype none
module gnssu_host (
  // clock
  input  wire logic        i_sys_clk,
  // line pair
  input  wire logic        i_line,
  output logic             o_line,
  // bit period in cycles
  input  wire logic [15:0] i_div
);
  // ****************************************************
  // host sender and receiver
  // ****************************************************
  logic [8:0] got_q [$];
  logic [8:0] sh;
  initial begin
    o_line = 1'b1;
  end
  // low start, lsb first, stop given by caller; no handshake lines
  task automatic send(input logic [7:0] d, input logic st);
    logic [9:0] f;
    f = {st, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_sys_clk);
      o_line <= f[i];
      repeat (i_div - 16'h1) @(posedge i_sys_clk);
    end
    @(posedge i_sys_clk);
    o_line <= 1'b1;
  endtask
  // device transmit feeds this receiver at the agreed rate
  always begin
    @(negedge i_line);
    repeat (i_div / 16'h2) @(posedge i_sys_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (i_div) @(posedge i_sys_clk);
      sh = {i_line, sh[8:1]};
    end
    got_q.push_back(sh);
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the receiver host port
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import gnssu_pkg::*;
;
  // ****************************************************
  // set-up, tasks and sequence
  // ****************************************************
  localparam int unsigned CLK_T = 1_152_000;
  localparam int unsigned PPS_T = 8;
  localparam int unsigned SEC_T = 50;
  localparam logic [14:0] ROWS [5] = '{{4'hf, 2'h0, 8'h55, 1'h1}, {4'hd, 2'h1, 8'ha3, 1'h0},
    {4'h2, 2'h1, 8'h3c, 1'h1}, {4'h8, 2'h3, 8'hff, 1'h1}, {4'h7, 2'h3, 8'h01, 1'h0}};
  logic        i_sys_clk = 1'b0, i_rst, i_tx_valid, i_fix_3d, i_utc_sec_mark, i_backup_mode;
  logic [7:0]  i_tx_data;
  logic [1:0]  i_tx_msg_type;
  logic [4:0]  i_sat_count;
  wire logic   i_rxd;
  logic        o_tx_ready, o_txd, o_rx_valid, o_rx_frame_err, o_second_tick_output, took;
  logic [7:0]  o_rx_data;
  logic [3:0]  o_msg_mask;
  logic [2:0]  o_rate_idx;
  logic [31:0] o_rtc_seconds, r0;
  logic [15:0] hdiv;
  int          err_count = 0, cmp_count = 0, cyc = 0, rx_cnt = 0, acc;
  gnssu_top #(.CLK_FREQ_HZ(CLK_T), .PPS_CYC(PPS_T), .SECOND_CYC(SEC_T),
    .TX_DEPTH(FIFO_DEPTH)) gnssu_top_i (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_tx_data(i_tx_data),
    .i_tx_msg_type(i_tx_msg_type), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
    .o_txd(o_txd), .i_rxd(i_rxd), .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid),
    .o_rx_frame_err(o_rx_frame_err), .i_fix_3d(i_fix_3d), .i_sat_count(i_sat_count),
    .i_utc_sec_mark(i_utc_sec_mark), .i_backup_mode(i_backup_mode),
    .o_second_tick_output(o_second_tick_output), .o_msg_mask(o_msg_mask),
    .o_rate_idx(o_rate_idx), .o_rtc_seconds(o_rtc_seconds));
  gnssu_host gnssu_host_i (.i_sys_clk(i_sys_clk), .i_line(o_txd), .o_line(i_rxd),
    .i_div(hdiv));
  always #12.5 i_sys_clk = ~i_sys_clk;
  function automatic logic [15:0] bdiv(input int unsigned r);
    return 16'((CLK_T + r / 2) / r);
  endfunction
  task automatic results();
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] d, input logic st);
    int c0 = rx_cnt;
    gnssu_host_i.send(d, st);
    for (int k = 0; k < 400 && rx_cnt == c0; k++) @(negedge i_sys_clk);
    check(rx_cnt - c0, 1);
    check({o_rx_data, o_rx_frame_err}, {d, ~st});
    repeat (3) @(negedge i_sys_clk);
  endtask
  task automatic tx_put(input logic [1:0] t, input logic [7:0] d);
    @(negedge i_sys_clk);
    i_tx_msg_type = t;
    i_tx_data = d;
    i_tx_valid = 1'b1;
    for (int k = 0; k < 50 && o_tx_ready !== 1'b1; k++) @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    i_tx_valid = 1'b0;
  endtask
  task automatic expect_frame(input logic [7:0] d, input logic hit);
    for (int k = 0; k < 16 * hdiv && gnssu_host_i.got_q.size() == 0; k++) @(negedge i_sys_clk);
    check(gnssu_host_i.got_q.size() != 0, hit);
    if (gnssu_host_i.got_q.size() != 0) check(gnssu_host_i.got_q.pop_front(), {1'b1, d});
  endtask
  task automatic pps_try(input logic fx, input logic [4:0] sc, input int drop, input int hi_x);
    int hi;
    hi = 0;
    @(negedge i_sys_clk);
    i_fix_3d = fx;
    i_sat_count = sc;
    i_utc_sec_mark = 1'b1;
    @(negedge i_sys_clk);
    i_utc_sec_mark = 1'b0;
    for (int k = 1; k <= 20; k++) begin
      if (o_second_tick_output === 1'b1) hi++;
      if (k == drop) i_fix_3d = 1'b0;
      @(negedge i_sys_clk);
    end
    check(hi, hi_x);
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (o_rx_valid === 1'b1) rx_cnt++;
    if (cyc == 30000) begin
      err_count++;
      results();
    end
  end
  initial begin
    {i_tx_valid, i_fix_3d, i_utc_sec_mark, i_backup_mode} = 4'h0;
    {i_tx_data, i_tx_msg_type, i_sat_count} = 15'h0000;
    i_rst = 1'b1;
    hdiv = bdiv(RATE_BPS[5]);
    repeat (5) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    foreach (ROWS[i]) begin
      cmd({4'ha, ROWS[i][14:11]}, 1'b1);
      check(o_msg_mask, ROWS[i][14:11]);
      tx_put(ROWS[i][10:9], ROWS[i][8:1]);
      expect_frame(ROWS[i][8:1], ROWS[i][0]);
    end
    cmd(8'haf, 1'b1);
    for (int r = 0; r < 6; r++) begin
      cmd(8'hb0 + 8'(r), 1'b1);
      check(o_rate_idx, r);
      hdiv = bdiv(RATE_BPS[r]);
      tx_put(2'h0, 8'h5a ^ 8'(r));
      expect_frame(8'h5a ^ 8'(r), 1'h1);
    end
    cmd(8'hb7, 1'b1);
    check(o_rate_idx, 3'h5);
    acc = 0;
    i_tx_data = 8'h80;
    i_tx_valid = 1'b1;
    repeat (24) begin
      took = o_tx_ready;
      @(negedge i_sys_clk);
      if (took === 1'b1) begin
        acc++;
        i_tx_data = i_tx_data + 8'h01;
      end
    end
    i_tx_valid = 1'b0;
    check(acc inside {16, 17}, 1'h1);
    for (int i = 0; i < acc; i++) expect_frame(8'h80 + 8'(i), 1'h1);
    expect_frame(8'h00, 1'h0);
    pps_try(1'b1, 5'h04, 0, PPS_T);
    pps_try(1'b1, 5'h03, 0, 0);
    pps_try(1'b0, 5'h09, 0, 0);
    pps_try(1'b1, 5'h1f, 3, 3);
    i_backup_mode = 1'b1;
    r0 = o_rtc_seconds;
    repeat (2 * SEC_T) @(negedge i_sys_clk);
    check(o_rtc_seconds - r0, 2);
    check({o_msg_mask, o_rate_idx}, {4'hf, 3'h5});
    tx_put(2'h0, 8'h3c);
    expect_frame(8'h00, 1'h0);
    i_backup_mode = 1'b0;
    expect_frame(8'h3c, 1'h1);
    cmd(8'ha0, 1'b0);
    check(o_msg_mask, 4'hf);
    repeat (150) @(negedge i_sys_clk);
    cmd(8'hb6, 1'b1);
    check(o_rate_idx, 3'h6);
    i_rst = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    check({o_txd, o_tx_ready, o_rx_valid, o_second_tick_output, o_msg_mask, o_rate_idx},
      {4'h8, 4'hf, 3'h5});
    check({o_rtc_seconds, o_rx_data, o_rx_frame_err}, 41'h0);
    i_rst = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    check(o_tx_ready, 1'h1);
    results();
  end
endmodule
`default_nettype wire
